// File: src/dds_nco_load_control.sv
// dds_nco_load_control: assembly registers, transfer logic and oscillator
// assumes: host pins are asynchronous; write and serial strobes are synchronised here
`timescale 1ns/1ps
`default_nettype none
module dds_nco_load_control (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic chip_sel_n,
   input wire logic write_n,
   input wire logic [15:0] data_in,
   input wire logic serial_clk,
   input wire logic serial_input_line,
   input wire logic load_strobe,
   input wire logic [3:0] transfer_code,
   input wire logic frequency_choice_input,
   input wire logic sleep_pin,
   output logic [9:0] dac_code,
   output logic dac_enable,
   output logic [3:0] command_state
);
   logic [3:0] command_control_reg;
   logic [31:0] par_asm_reg;
   logic [31:0] ser_asm_reg;
   logic [31:0] frequency_word_0_reg;
   logic [31:0] frequency_word_1_reg;
   logic [11:0] phase_offset_reg;
   logic [19:0] iq_amplitude_register_reg;
   logic [31:0] acc_reg;
   logic [9:0] dac_reg;
   logic wr_fall;
   logic sclk_rise;
   logic ld_level;
   logic sleep_level;
   logic fs_level;
   logic [3:0] tc_level;
   logic [3:0] pipe_ld_reg;
   logic [3:0] pipe_fs_reg;
   logic [3:0] pipe_tc_reg [4];
   logic ld_use;
   logic fs_use;
   logic [3:0] tc_use;
   logic [31:0] src_word;
   logic xfer_pulse;
   logic run;
   logic wr_active;
   logic [11:0] lut_addr;
   logic [9:0] sine_val;
   logic [9:0] cosine_val;
   logic [19:0] i_prod;
   logic [19:0] q_prod;
   logic [9:0] iq_sum;
   logic [31:0] phase_sum;
   nco_pkg::xfer_state_t xfer_state_reg;

   // ==========================================
   // pin synchronisers
   assign wr_active = !(chip_sel_n || write_n);

   edge_sync u_wr_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pin_in(wr_active),
      .level_out(),
      .rise_out(wr_fall)
   );

   edge_sync u_sclk_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pin_in(serial_clk),
      .level_out(),
      .rise_out(sclk_rise)
   );

   edge_sync u_ld_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pin_in(load_strobe),
      .level_out(ld_level),
      .rise_out()
   );

   edge_sync u_fs_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pin_in(frequency_choice_input),
      .level_out(fs_level),
      .rise_out()
   );

   // the sleep pin stops the core only through the guard, so no flop sees it raw
   edge_sync u_sleep_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pin_in(sleep_pin),
      .level_out(sleep_level),
      .rise_out()
   );

   genvar gi;
   generate
      for (gi = 0; gi < nco_pkg::TC_WIDTH; gi++) begin : g_tc_sync
         edge_sync u_tc_sync (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .pin_in(transfer_code[gi]),
            .level_out(tc_level[gi]),
            .rise_out()
         );
      end
   endgenerate

   // ==========================================
   // four-stage control pipeline, kept running even in bypass, so leaving bypass mid-load replays the load pulse
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pipe_ld_reg <= 4'h0;
         pipe_fs_reg <= 4'h0;
         for (int i = 0; i < nco_pkg::SYNC_STAGES; i++) begin
            pipe_tc_reg[i] <= 4'h0;
         end
      end else begin
         pipe_ld_reg <= {pipe_ld_reg[2:0], ld_level};
         pipe_fs_reg <= {pipe_fs_reg[2:0], fs_level};
         pipe_tc_reg[0] <= tc_level;
         for (int i = 1; i < nco_pkg::SYNC_STAGES; i++) begin
            pipe_tc_reg[i] <= pipe_tc_reg[i-1];
         end
      end
   end

   // bypass still passes the pin guard, so metastability stays contained
   always_comb begin
      if (command_control_reg[nco_pkg::SYNC_BYPASS_POS]) begin
         ld_use = ld_level;
         fs_use = fs_level;
         tc_use = tc_level;
      end else begin
         ld_use = pipe_ld_reg[3];
         fs_use = pipe_fs_reg[3];
         tc_use = pipe_tc_reg[3];
      end
   end

   // ==========================================
   // parallel assembly register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         par_asm_reg <= nco_pkg::WORD_RESET;
      end else if (wr_fall) begin
         if (command_control_reg[nco_pkg::BUS_WIDTH_POS]) begin
            par_asm_reg <= {par_asm_reg[15:0], data_in};
         end else begin
            par_asm_reg <= {par_asm_reg[23:0], data_in[7:0]};
         end
      end
   end

   // ==========================================
   // serial assembly register, independent of the parallel path
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ser_asm_reg <= nco_pkg::WORD_RESET;
      end else if (sclk_rise) begin
         ser_asm_reg <= {ser_asm_reg[30:0], serial_input_line};
      end
   end

   // ==========================================
   // transfer strobe: one copy per high pulse, two when that copy clears the bypass bit
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         xfer_state_reg <= nco_pkg::XFER_IDLE;
      end else begin
         case (xfer_state_reg)
            nco_pkg::XFER_IDLE: begin
               if (ld_use) begin
                  xfer_state_reg <= nco_pkg::XFER_HOLD;
               end
            end
            nco_pkg::XFER_HOLD: begin
               if (!ld_use) begin
                  xfer_state_reg <= nco_pkg::XFER_IDLE;
               end
            end
            default: xfer_state_reg <= nco_pkg::XFER_IDLE;
         endcase
      end
   end

   assign xfer_pulse = ld_use && (xfer_state_reg == nco_pkg::XFER_IDLE);

   // ==========================================
   // command register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         command_control_reg <= nco_pkg::CMD_RESET;
      end else if (xfer_pulse && !tc_use[nco_pkg::TC_DEST_POS]) begin
         command_control_reg <= par_asm_reg[3:0];
      end
   end

   // ==========================================
   // modulation registers
   function automatic logic [31:0] pick_source(input logic [3:0] code, input logic [31:0] par,
                                               input logic [31:0] ser);
      pick_source = code[nco_pkg::TC_SERIAL_POS] ? ser : par;
   endfunction : pick_source

   assign src_word = pick_source(tc_use, par_asm_reg, ser_asm_reg);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         frequency_word_0_reg <= nco_pkg::WORD_RESET;
         frequency_word_1_reg <= nco_pkg::WORD_RESET;
         phase_offset_reg <= 12'h000;
         iq_amplitude_register_reg <= 20'h00000;
      end else if (xfer_pulse && tc_use[nco_pkg::TC_DEST_POS]) begin
         case (tc_use[1:0])
            nco_pkg::DEST_FREQUENCY_WORD_0: frequency_word_0_reg <= src_word;
            nco_pkg::DEST_FREQUENCY_WORD_1: frequency_word_1_reg <= src_word;
            nco_pkg::DEST_PHASE: phase_offset_reg <= src_word[11:0];
            nco_pkg::DEST_IQ: iq_amplitude_register_reg <= src_word[19:0];
            default: phase_offset_reg <= phase_offset_reg;
         endcase
      end
   end

   // ==========================================
   // numeric oscillator
   assign run = !(command_control_reg[nco_pkg::SLEEP_POS] || sleep_level);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_reg <= nco_pkg::WORD_RESET;
      end else if (run) begin
         // no reset on a word switch keeps the phase continuous
         acc_reg <= acc_reg + (fs_use ? frequency_word_1_reg : frequency_word_0_reg);
      end
   end

   assign phase_sum = acc_reg + {phase_offset_reg, 20'h00000};
   assign lut_addr = phase_sum[31:20];

   // ==========================================
   // sine/cosine table, computed from a quarter-wave parabola approximation
   // trades table accuracy for area; shape is symmetric and signed
   function automatic logic [9:0] wave(input logic [11:0] addr);
      logic [9:0] x;
      logic [19:0] sq;
      logic [9:0] mag;
      x = addr[10] ? ~addr[9:0] : addr[9:0];
      sq = x * x;
      mag = 10'h1ff - {1'b0, sq[19:11]};
      mag = 10'h1ff - mag;
      wave = addr[11] ? (~{1'b0, mag[8:0]} + 10'h001) : {1'b0, mag[8:0]};
   endfunction : wave

   assign sine_val = wave(lut_addr);
   assign cosine_val = wave(lut_addr + 12'h400);

   // signed fractions; product keeps the top bits, sum simply wraps
   assign i_prod = $signed({{10{cosine_val[9]}}, cosine_val})
                 * $signed({{10{iq_amplitude_register_reg[9]}}, iq_amplitude_register_reg[9:0]});
   assign q_prod = $signed({{10{sine_val[9]}}, sine_val})
                 * $signed({{10{iq_amplitude_register_reg[19]}}, iq_amplitude_register_reg[19:10]});
   assign iq_sum = i_prod[18:9] + q_prod[18:9];

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dac_reg <= 10'h000;
      end else if (run) begin
         if (command_control_reg[nco_pkg::AM_ENABLE_POS]) begin
            dac_reg <= iq_sum;
         end else begin
            dac_reg <= sine_val;
         end
      end
   end

   assign dac_code = dac_reg;
   // the current gate follows the raw pin at once; the core halts a few clocks later
   assign dac_enable = !(command_control_reg[nco_pkg::SLEEP_POS] || sleep_pin);
   assign command_state = command_control_reg;
endmodule : dds_nco_load_control
`default_nettype wire

// File: src/edge_sync.sv
// edge_sync: three-flop synchroniser with agreement check for one pin
// assumes: the pin is asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic pin_in,
   output logic level_out,
   output logic rise_out
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_reg;

   // ==========================================
   // capture chain; only s2 reads s1
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // a change counts once second and third stages agree
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         level_reg <= 1'b0;
      end else if (s2_reg == s3_reg) begin
         level_reg <= s3_reg;
      end
   end

   assign level_out = level_reg;
   assign rise_out = (s2_reg == s3_reg) && s3_reg && !level_reg;
endmodule : edge_sync
`default_nettype wire

// File: src/nco_pkg.sv
// package: constants for the synthesis core and its load control
// assumes: one 200 MHz system clock, asynchronous active-low reset
package nco_pkg;
   // ==========================================
   // command register bit positions
   localparam int CMD_WIDTH = 4;
   localparam int BUS_WIDTH_POS = 0;
   localparam int SLEEP_POS = 1;
   localparam int AM_ENABLE_POS = 2;
   localparam int SYNC_BYPASS_POS = 3;
   localparam logic [3:0] CMD_RESET = 4'h0;
   // ==========================================
   // datapath widths and reset values
   localparam int ACC_WIDTH = 32;
   localparam int PHASE_WIDTH = 12;
   localparam int IQ_WIDTH = 20;
   localparam int AMP_WIDTH = 10;
   localparam int LUT_ADDR_WIDTH = 12;
   localparam int SYNC_STAGES = 4;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   // ==========================================
   // transfer code fields
   localparam int TC_WIDTH = 4;
   localparam int TC_DEST_POS = 3;
   localparam int TC_SERIAL_POS = 2;
   localparam logic [1:0] DEST_FREQUENCY_WORD_0 = 2'h0;
   localparam logic [1:0] DEST_FREQUENCY_WORD_1 = 2'h1;
   localparam logic [1:0] DEST_PHASE = 2'h2;
   localparam logic [1:0] DEST_IQ = 2'h3;
   typedef enum {XFER_IDLE, XFER_HOLD} xfer_state_t;
endpackage : nco_pkg

// File: verif/dds_nco_load_control_bench.sv
// bench: self-checking test of the load control through its pins
// assumes: host_model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module dds_nco_load_control_bench;
   // ==========================================
   // signals, clock and instances
   logic sys_clk, rst_n, sleep_pin, fsel, chip_sel_n, write_n, serial_clk, serial_input_line, load_strobe;
   logic [15:0] data_in;
   logic [3:0] transfer_code, command_state;
   logic [9:0] dac_code, d_ref;
   logic dac_enable;
   logic [31:0] r;
   int error_cnt, check_count, seed, lat, lat_sync;
   initial sys_clk = 1'b0;
   always #2.5 sys_clk = ~sys_clk;
   host_model host (.sys_clk(sys_clk), .chip_sel_n(chip_sel_n), .write_n(write_n), .data_in(data_in),
      .serial_clk(serial_clk), .serial_input_line(serial_input_line), .load_strobe(load_strobe),
      .transfer_code(transfer_code));
   dds_nco_load_control DUT (.sys_clk(sys_clk), .rst_n(rst_n), .chip_sel_n(chip_sel_n), .write_n(write_n),
      .data_in(data_in), .serial_clk(serial_clk), .serial_input_line(serial_input_line),
      .load_strobe(load_strobe), .transfer_code(transfer_code), .frequency_choice_input(fsel),
      .sleep_pin(sleep_pin), .dac_code(dac_code), .dac_enable(dac_enable), .command_state(command_state));
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (exp !== got) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic give_verdict();
      if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   // one write, then a held load until the copy shows; lat is the cycles seen
   task automatic set_cmd(input logic [3:0] v, input logic [3:0] code);
      r = $random(seed);
      host.par_write({r[15:4], v});
      host.load_begin(code);
      lat = 0;
      while (command_state !== v && lat < 40) begin
         cyc(1);
         lat++;
      end
      host.load_end();
      check("command_state", v, command_state);
   endtask : set_cmd
   task automatic ref_ser(input logic [1:0] dst, input logic [19:0] v);
      host.ser_shift({12'h000, v});
      host.load({2'b11, dst});
      cyc(6);
      d_ref = dac_code;
   endtask : ref_ser
   // a different value goes in serially first, so a dead parallel path shows
   task automatic via_par(input logic [3:0] mode, input logic [1:0] dst, input logic [19:0] v);
      r = $random(seed);
      host.ser_shift({r[31:20], v ^ 20'h80a00});
      host.load({2'b11, dst});
      set_cmd(mode, 4'h0);
      if (mode[0]) begin
         host.par_write({r[11:0], v[19:16]});
         host.par_write(v[15:0]);
      end else begin
         host.par_write(r[15:0]);
         host.par_write(r[31:16]);
         host.par_write({r[7:0], r[3:0], v[11:8]});
         host.par_write({r[15:8], v[7:0]});
      end
      host.load({2'b10, dst});
      cyc(6);
      check("dac_code", d_ref, dac_code);
   endtask : via_par
   initial begin
      #200us;
      error_cnt++;
      give_verdict();
   end
   initial begin
      {error_cnt, check_count, seed} = {32'sd0, 32'sd0, 32'sd47};
      {rst_n, sleep_pin, fsel} = 3'h0;
      repeat (16) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      check("command_state", 4'h0, command_state);
      check("dac_enable", 1'b1, dac_enable);
      cyc(4);
      host.ser_shift(32'hffff_ffff);
      for (int i = 0; i < 8; i++) set_cmd(4'($random(seed)) & 4'hd, i[3:0]);
      set_cmd(4'h0, 4'h0);
      set_cmd(4'h4, 4'h1);
      lat_sync = lat;
      set_cmd(4'h8, 4'h2);
      set_cmd(4'hc, 4'h3);
      check("bypass faster", 1'b1, lat < lat_sync);
      set_cmd(4'h0, 4'h0);
      r = $random(seed);
      // offset kept mid-quadrant, away from the zero crossings of the wave
      ref_ser(2'h2, {8'h00, 3'b010, r[8:0]} + 20'h00100);
      check("dac nonzero", 1'b1, d_ref != 10'h000);
      via_par(4'h0, 2'h2, {8'h00, 3'b010, r[8:0]} + 20'h00100);
      set_cmd(4'h5, 4'h0);
      cyc(6);
      check("dac_code", 10'h000, dac_code);
      r = $random(seed);
      ref_ser(2'h3, r[19:0]);
      via_par(4'h5, 2'h3, r[19:0]);
      // first copy sets byte mode; a repeated copy would pick up the later write
      host.par_write(16'h0004);
      host.load_begin(4'h0);
      cyc(12);
      host.par_write(16'h0001);
      cyc(12);
      host.load_end();
      check("command_state", 4'h4, command_state);
      set_cmd(4'h1, 4'h0);
      host.ser_shift(32'h0100_0000);
      host.load(4'hd);
      fsel = 1'b1;
      cyc(12);
      d_ref = dac_code;
      cyc(40);
      check("dac moving", 1'b1, dac_code != d_ref);
      fsel = 1'b0;
      cyc(12);
      d_ref = dac_code;
      cyc(30);
      check("dac held", d_ref, dac_code);
      fsel = 1'b1;
      sleep_pin = 1'b1;
      cyc(8);
      check("dac_enable", 1'b0, dac_enable);
      d_ref = dac_code;
      cyc(20);
      check("dac frozen", d_ref, dac_code);
      sleep_pin = 1'b0;
      set_cmd(4'h3, 4'h0);
      check("dac_enable", 1'b0, dac_enable);
      rst_n = 1'b0;
      cyc(3);
      check("command_state", 4'h0, command_state);
      rst_n = 1'b1;
      cyc(4);
      give_verdict();
   end
endmodule : dds_nco_load_control_bench
`default_nettype wire

// File: verif/dds_nco_load_control_props.sv
// checker: port-level properties of the load control
// assumes: bound to dds_nco_load_control, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dds_nco_load_control_props (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic load_strobe,
   input wire logic sleep_pin,
   input wire logic [9:0] dac_code,
   input wire logic dac_enable,
   input wire logic [3:0] command_state
);
   // ==========================================
   // helpers: cycles since load, copies per pulse
   logic [4:0] since_reg;
   logic [1:0] copies_reg;
   logic load_q_reg;
   logic [3:0] cmd_q_reg;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) since_reg <= 5'h1f;
      else if (load_strobe) since_reg <= 5'h00;
      else if (since_reg != 5'h1f) since_reg <= since_reg + 5'h01;
   end
   // copies counted from each rise; pulses are spaced wider than the latency
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         copies_reg <= 2'h0;
         load_q_reg <= 1'b0;
         cmd_q_reg <= 4'h0;
      end else begin
         load_q_reg <= load_strobe;
         cmd_q_reg <= command_state;
         if (load_strobe && !load_q_reg) copies_reg <= 2'h0;
         else if (command_state != cmd_q_reg && copies_reg != 2'h3) copies_reg <= copies_reg + 2'h1;
      end
   end
   sequence load_rise_s; $rose(load_strobe); endsequence
   sequence sleep_held_s; sleep_pin [*6]; endsequence
   a_reset_clears: assert property (disable iff (1'b0) !rst_n |-> command_state == 4'h0 && dac_code == 10'h000)
      else $error("command or dac not cleared in reset");
   a_pin_sleep_off: assert property (sleep_pin |-> !dac_enable)
      else $error("dac enabled while sleep pin high");
   a_cmd_sleep_off: assert property (command_state[nco_pkg::SLEEP_POS] |-> !dac_enable)
      else $error("dac enabled while sleep bit set");
   a_awake_enabled: assert property (!sleep_pin && !command_state[nco_pkg::SLEEP_POS] |-> dac_enable)
      else $error("dac disabled while awake");
   a_sleep_freezes: assert property (sleep_held_s |=> $stable(dac_code))
      else $error("dac code moved in sleep");
   a_load_no_early: assert property (load_rise_s |=> $stable(command_state) [*2])
      else $error("command changed before synchroniser delay");
   a_cmd_needs_load: assert property (command_state != cmd_q_reg |-> since_reg < 5'h10)
      else $error("command changed without load");
   a_one_copy: assert property (copies_reg <= 2'h1)
      else $error("more than one copy per load pulse");
endmodule : dds_nco_load_control_props
bind dds_nco_load_control dds_nco_load_control_props props (.sys_clk(sys_clk), .rst_n(rst_n),
   .load_strobe(load_strobe), .sleep_pin(sleep_pin), .dac_code(dac_code), .dac_enable(dac_enable),
   .command_state(command_state));
`default_nettype wire

// File: verif/host_model.sv
// host_model: processor side driving the parallel, serial and load pins
// assumes: tasks called from the bench just after a rising sys_clk edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic sys_clk,
   output logic chip_sel_n,
   output logic write_n,
   output logic [15:0] data_in,
   output logic serial_clk,
   output logic serial_input_line,
   output logic load_strobe,
   output logic [3:0] transfer_code
);
   // ==========================================
   // pin drivers
   initial begin
      {chip_sel_n, write_n} = 2'h3;
      data_in = 16'h0000;
      {serial_clk, serial_input_line, load_strobe} = 3'h0;
      transfer_code = 4'h0;
   end
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step
   // strobes low and high for several clocks so the pin guard sees each phase
   task automatic par_write(input logic [15:0] d);
      data_in = d;
      {chip_sel_n, write_n} = 2'h0;
      step(5);
      {chip_sel_n, write_n} = 2'h3;
      step(1);
      data_in = ~d;
      step(4);
   endtask : par_write
   task automatic ser_shift(input logic [31:0] d);
      for (int i = 31; i >= 0; i--) begin
         serial_input_line = d[i];
         step(2);
         serial_clk = 1'b1;
         step(4);
         serial_clk = 1'b0;
      end
      serial_input_line = ~d[0];
   endtask : ser_shift
   task automatic load_begin(input logic [3:0] code);
      transfer_code = code;
      step(2);
      load_strobe = 1'b1;
      // two clocks at least: a one-clock pulse never reaches agreement in the pin guard
      step(2);
   endtask : load_begin
   task automatic load_end();
      load_strobe = 1'b0;
      step(6);
   endtask : load_end
   task automatic load(input logic [3:0] code);
      load_begin(code);
      step(12);
      load_end();
   endtask : load
endmodule : host_model
`default_nettype wire
